// ===== dsx_exec_unit.sv
// Execution datapath for packed load, packed store and translated move.
// Assumes a same-clock byte memory that answers each request with mem_ack.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps

// Summary of operation
// [RL1] Conversions single operand, others two operands
// [RL2] Lengths from register or immediate, bytes
// [RL3] Immediate 0..15, register full range
// [RL4] Interruptible; set status bit 14 on interrupt
// [RL5] Opcode 6F converts 16 packed bytes
// [RL6] Load condition: zero, less, greater, overflow
// [RL7] Bad digit: registers kept, format fault
// [RL8] Overflow above largest positive 64-bit value
// [RL9] Software names an even register pair
// [RL10] Opcode 6E stores 16 bytes, MSB first
// [RL11] Store condition: zero, less, greater only
// [RL12] Escape byte from register 0 low byte
// [RL13] Nonzero register 2 selects table lookup
// [RL14] Escape match sets C, not stored
// [RL15] Ends on escape, full or exhausted
// [RL16] Register 1 gets next source address
// [RL17] Bytes move lowest to highest address
// [RL18] Sign nibble C3AEF plus, DB minus
// [RL19] Digits 0..9, sign in last nibble
// [RL20] Store emits standard sign, zero fill
module dsx_exec_unit (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic resume,
   input wire logic [7:0] opcode,
   input wire logic [7:0] func_code,
   input wire logic [31:0] pair_even_in,
   input wire logic [31:0] pair_odd_in,
   input wire logic [31:0] gpr0_in,
   input wire logic [31:0] gpr2_in,
   input wire logic len1_from_reg,
   input wire logic [3:0] len1_imm,
   input wire logic [31:0] len1_reg,
   input wire logic len2_from_reg,
   input wire logic [3:0] len2_imm,
   input wire logic [31:0] len2_reg,
   input wire logic [31:0] addr1,
   input wire logic [31:0] addr2,
   input wire logic intr_req,
   input wire logic [0:31] psw_in,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack,
   output logic busy,
   output logic done,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic pair_we,
   output logic [31:0] pair_even_out,
   output logic [31:0] pair_odd_out,
   output logic gpr1_we,
   output logic [31:0] gpr1_out,
   output logic cc_we,
   output logic [3:0] cc_out,
   output logic fmt_fault,
   output logic intr_taken,
   output logic [0:31] old_psw_out
);
   dsx_pkg::dsx_ctx_t s_reg;
   dsx_pkg::dsx_ctx_t s_next;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // [RL2] [RL3] length select
   function automatic logic [31:0] sel_len(input logic from_reg, input logic [3:0] imm,
                                           input logic [31:0] regv);
      sel_len = from_reg ? regv : {28'h0, imm};
   endfunction

   // [RL19] digit range
   function automatic logic dig_ok(input logic [3:0] d);
      dig_ok = d <= dsx_pkg::DIGIT_MAX;
   endfunction

   // [RL18] sign decoding
   function automatic logic sign_neg(input logic [3:0] d);
      sign_neg = d == dsx_pkg::SIGN_NEG || d == dsx_pkg::SIGN_NEG_ALT;
   endfunction

   function automatic logic sign_ok(input logic [3:0] d);
      sign_ok = sign_neg(d) || d == dsx_pkg::SIGN_POS || d == dsx_pkg::SIGN_POS_3 ||
                d == dsx_pkg::SIGN_POS_A || d == dsx_pkg::SIGN_POS_E ||
                d == dsx_pkg::SIGN_POS_F;
   endfunction

   function automatic logic [67:0] mul10add(input logic [63:0] a, input logic [3:0] d);
      mul10add = {4'h0, a} * dsx_pkg::DEC_BASE + {64'h0, d};
   endfunction

   // Double-dabble adjust on all 32 nibbles
   function automatic logic [127:0] dd_add3(input logic [127:0] b);
      logic [127:0] r;
      r = b;
      for (int i = 0; i < dsx_pkg::BCD_DIGITS; i++) begin
         if (r[i*4 +: 4] >= dsx_pkg::BCD_ADJ_MIN) begin
            r[i*4 +: 4] = r[i*4 +: 4] + dsx_pkg::BCD_ADJ;
         end
      end
      dd_add3 = r;
   endfunction

   function automatic logic [3:0] cc_sign(input logic zero, input logic neg);
      cc_sign = zero ? dsx_pkg::CC_NONE : (neg ? dsx_pkg::CC_LT : dsx_pkg::CC_GT);
   endfunction

   function automatic dsx_pkg::dsx_ctx_t finish(input dsx_pkg::dsx_ctx_t c,
                                                input logic [3:0] cc);
      c.cc_we = 1'b1;
      c.cc = cc;
      c.busy = 1'b0;
      c.done = 1'b1;
      c.st = dsx_pkg::ST_IDLE;
      finish = c;
   endfunction

   // [RL4] park state, flag resumable status word
   function automatic dsx_pkg::dsx_ctx_t take_intr(input dsx_pkg::dsx_ctx_t c,
                                                   input logic [0:31] processor_status_word);
      // Status word bits count from the left, so flag it in that order
      logic [0:31] p;
      p = processor_status_word;
      p[dsx_pkg::PSW_IIP_BIT] = 1'b1;
      c.saved = c.st;
      c.st = dsx_pkg::ST_IDLE;
      c.busy = 1'b0;
      c.instruction_in_progress_flag = 1'b1;
      c.intr_taken = 1'b1;
      c.old_psw = p;
      take_intr = c;
   endfunction

   // [RL15] [RL16] end of translated move
   function automatic dsx_pkg::dsx_ctx_t mv_end(input dsx_pkg::dsx_ctx_t c,
                                                input logic [3:0] cc);
      c.gpr1_we = 1'b1;
      c.gpr1 = c.src;
      mv_end = finish(c, cc);
   endfunction

   // [RL14] escape compare, else store at destination
   function automatic dsx_pkg::dsx_ctx_t mv_arg(input dsx_pkg::dsx_ctx_t c,
                                                input logic [7:0] b);
      if (b == c.esc) begin
         c.mem_req = 1'b0;
         mv_arg = mv_end(c, dsx_pkg::CC_ESC);
      end else begin
         c.mem_req = 1'b1;
         c.mem_we = 1'b1;
         c.mem_addr = c.dst;
         c.mem_wdata = b;
         c.st = dsx_pkg::ST_MV_WR;
         mv_arg = c;
      end
   endfunction

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb begin
      logic [67:0] p1;
      logic [67:0] p2;
      logic [127:0] sh;
      logic [63:0] val;
      logic bad;
      p1 = '0;
      p2 = '0;
      sh = '0;
      val = {pair_even_in, pair_odd_in};
      bad = 1'b0;
      s_next = s_reg;
      s_next.pair_we = 1'b0;
      s_next.gpr1_we = 1'b0;
      s_next.cc_we = 1'b0;
      s_next.fault = 1'b0;
      s_next.done = 1'b0;
      s_next.intr_taken = 1'b0;
      case (s_reg.st)
         dsx_pkg::ST_IDLE: begin
            if (start) begin
               s_next.busy = 1'b1;
               // Resume keeps the parked byte count
               if (resume && s_reg.instruction_in_progress_flag) begin
                  s_next.st = s_reg.saved;
                  s_next.instruction_in_progress_flag = 1'b0;
               // [RL1] [RL5] single operand, address from second field
               end else if (opcode == dsx_pkg::OP_LOAD_PACKED) begin
                  s_next.st = dsx_pkg::ST_LD_RD;
                  s_next.cnt = '0;
                  s_next.src = addr2;
                  s_next.acc = '0;
                  s_next.ovf = 1'b0;
               // [RL10] magnitude taken up front, sign kept aside
               end else if (opcode == dsx_pkg::OP_STORE_PACKED) begin
                  s_next.st = dsx_pkg::ST_ST_CONV;
                  s_next.cnt = '0;
                  s_next.src = addr2;
                  s_next.neg = val[63];
                  s_next.zero = val == '0;
                  s_next.acc = val[63] ? -val : val;
                  s_next.bcd = '0;
                  s_next.dd = '0;
               // [RL1] [RL12] two operands, escape and table latched
               end else if (opcode == dsx_pkg::OP_MOVE_XLATE &&
                            func_code == dsx_pkg::FN_MOVE_XLATE) begin
                  s_next.st = dsx_pkg::ST_MV_SRC;
                  s_next.src = addr2;
                  s_next.dst = addr1;
                  s_next.rem1 = sel_len(len1_from_reg, len1_imm, len1_reg);
                  s_next.rem2 = sel_len(len2_from_reg, len2_imm, len2_reg);
                  s_next.esc = gpr0_in[dsx_pkg::ESC_HI:0];
                  s_next.tab = gpr2_in;
               end else begin
                  s_next.busy = 1'b0;
                  s_next.done = 1'b1;
               end
            end
         end
         dsx_pkg::ST_LD_RD: begin
            if (!s_reg.mem_req) begin
               if (intr_req) begin
                  s_next = take_intr(s_next, psw_in);
               end else begin
                  s_next.mem_req = 1'b1;
                  s_next.mem_we = 1'b0;
                  s_next.mem_addr = s_reg.src;
               end
            end else if (mem_ack) begin
               s_next.mem_req = 1'b0;
               s_next.src = s_reg.src + 32'h1;
               s_next.cnt = s_reg.cnt + 5'h1;
               // [RL19] high nibble first; last low nibble is sign
               p1 = mul10add(s_reg.acc, mem_rdata[7:4]);
               // [RL8] sticky overflow past largest positive value
               s_next.ovf = s_reg.ovf || p1 > {4'h0, dsx_pkg::MAG_MAX};
               if (s_reg.cnt == dsx_pkg::PACKED_LAST) begin
                  bad = !dig_ok(mem_rdata[7:4]) || !sign_ok(mem_rdata[3:0]);
                  s_next.acc = p1[63:0];
                  s_next.neg = sign_neg(mem_rdata[3:0]);
                  s_next.st = dsx_pkg::ST_LD_FIN;
               end else begin
                  bad = !dig_ok(mem_rdata[7:4]) || !dig_ok(mem_rdata[3:0]);
                  p2 = mul10add(p1[63:0], mem_rdata[3:0]);
                  s_next.ovf = s_next.ovf || p2 > {4'h0, dsx_pkg::MAG_MAX};
                  s_next.acc = p2[63:0];
               end
               // [RL7] fault ends early, pair untouched
               if (bad) begin
                  s_next.fault = 1'b1;
                  s_next.busy = 1'b0;
                  s_next.done = 1'b1;
                  s_next.st = dsx_pkg::ST_IDLE;
               end
            end
         end
         dsx_pkg::ST_LD_FIN: begin
            // [RL6] [RL8] overflow reports V alone
            if (s_reg.ovf) begin
               s_next = finish(s_next, dsx_pkg::CC_OVF);
            end else begin
               s_next.pair_we = 1'b1;
               s_next.pair = s_reg.neg ? -s_reg.acc : s_reg.acc;
               s_next = finish(s_next, cc_sign(s_reg.acc == '0, s_reg.neg));
            end
         end
         dsx_pkg::ST_ST_CONV: begin
            sh = dd_add3(s_reg.bcd);
            sh = {sh[126:0], s_reg.acc[63]};
            s_next.acc = {s_reg.acc[62:0], 1'b0};
            s_next.dd = s_reg.dd + 7'h1;
            s_next.bcd = sh;
            // [RL20] standard sign appended, leading digits stay zero
            if (s_reg.dd == dsx_pkg::DD_LAST) begin
               s_next.bcd = {sh[123:0], s_reg.neg ? dsx_pkg::SIGN_NEG : dsx_pkg::SIGN_POS};
               s_next.st = dsx_pkg::ST_ST_WR;
            end
         end
         dsx_pkg::ST_ST_WR: begin
            // [RL10] most significant byte to lowest address
            if (!s_reg.mem_req) begin
               if (intr_req) begin
                  s_next = take_intr(s_next, psw_in);
               end else begin
                  s_next.mem_req = 1'b1;
                  s_next.mem_we = 1'b1;
                  s_next.mem_addr = s_reg.src;
                  s_next.mem_wdata = s_reg.bcd[127:120];
               end
            end else if (mem_ack) begin
               s_next.mem_req = 1'b0;
               s_next.mem_we = 1'b0;
               s_next.src = s_reg.src + 32'h1;
               s_next.bcd = {s_reg.bcd[119:0], 8'h0};
               s_next.cnt = s_reg.cnt + 5'h1;
               // [RL11] no overflow case
               if (s_reg.cnt == dsx_pkg::PACKED_LAST) begin
                  s_next = finish(s_next, cc_sign(s_reg.zero, s_reg.neg));
               end
            end
         end
         dsx_pkg::ST_MV_SRC: begin
            // [RL15] exhausted source wins over full destination
            if (!s_reg.mem_req) begin
               if (s_reg.rem2 == '0) begin
                  s_next = mv_end(s_next, dsx_pkg::CC_NONE);
               end else if (s_reg.rem1 == '0) begin
                  s_next = mv_end(s_next, dsx_pkg::CC_OVF);
               end else if (intr_req) begin
                  s_next = take_intr(s_next, psw_in);
               end else begin
                  s_next.mem_req = 1'b1;
                  s_next.mem_we = 1'b0;
                  s_next.mem_addr = s_reg.src;
               end
            // [RL13] table entry replaces the argument byte
            end else if (mem_ack) begin
               if (s_reg.tab != '0) begin
                  s_next.mem_addr = s_reg.tab + {24'h0, mem_rdata};
                  s_next.st = dsx_pkg::ST_MV_TAB;
               end else begin
                  s_next = mv_arg(s_next, mem_rdata);
               end
            end
         end
         dsx_pkg::ST_MV_TAB: begin
            if (mem_ack) begin
               s_next = mv_arg(s_next, mem_rdata);
            end
         end
         dsx_pkg::ST_MV_WR: begin
            // [RL17] strictly ascending addresses
            if (mem_ack) begin
               s_next.mem_req = 1'b0;
               s_next.mem_we = 1'b0;
               s_next.src = s_reg.src + 32'h1;
               s_next.dst = s_reg.dst + 32'h1;
               s_next.rem1 = s_reg.rem1 - 32'h1;
               s_next.rem2 = s_reg.rem2 - 32'h1;
               s_next.st = dsx_pkg::ST_MV_SRC;
            end
         end
         default: s_next.st = dsx_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_reg <= dsx_pkg::CTX_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign busy = s_reg.busy;
   assign done = s_reg.done;
   assign mem_req = s_reg.mem_req;
   assign mem_we = s_reg.mem_we;
   assign mem_addr = s_reg.mem_addr;
   assign mem_wdata = s_reg.mem_wdata;
   assign pair_we = s_reg.pair_we;
   assign pair_even_out = s_reg.pair[63:32];
   assign pair_odd_out = s_reg.pair[31:0];
   assign gpr1_we = s_reg.gpr1_we;
   assign gpr1_out = s_reg.gpr1;
   assign cc_we = s_reg.cc_we;
   assign cc_out = s_reg.cc;
   assign fmt_fault = s_reg.fault;
   assign intr_taken = s_reg.intr_taken;
   assign old_psw_out = s_reg.old_psw;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence load_issue;
      start && !resume && opcode == dsx_pkg::OP_LOAD_PACKED ##1 !intr_req;
   endsequence

   chk_load_first_addr: assert property ( // [RL1]
      load_issue |=> mem_req && !mem_we && mem_addr == $past(addr2, 2))
      else $error("load did not fetch from operand address");
   chk_fault_no_write: assert property ( // [RL7]
      fmt_fault |-> !pair_we && done)
      else $error("format fault wrote the register pair");
   chk_cc_one_hot: assert property ( // [RL6]
      cc_we |-> $onehot0(cc_out))
      else $error("condition code has more than one bit");
   chk_ovf_no_pair: assert property ( // [RL8]
      cc_we && cc_out[dsx_pkg::CC_V] |-> !pair_we)
      else $error("overflow wrote the register pair");
   chk_esc_ends_move: assert property ( // [RL14]
      s_reg.st == dsx_pkg::ST_MV_SRC && mem_ack && s_reg.tab == '0 &&
      mem_rdata == s_reg.esc |=> cc_we && cc_out == dsx_pkg::CC_ESC && gpr1_we && !mem_req)
      else $error("escape byte did not end the move");
   chk_xlate_lookup: assert property ( // [RL13]
      s_reg.st == dsx_pkg::ST_MV_SRC && mem_ack && s_reg.tab != '0 |=>
      mem_req && !mem_we && mem_addr == $past(s_reg.tab) + {24'h0, $past(mem_rdata)})
      else $error("table lookup address wrong");
   chk_mv_ascending: assert property ( // [RL17]
      s_reg.st == dsx_pkg::ST_MV_WR && mem_ack |=> s_reg.dst == $past(s_reg.dst) + 32'h1)
      else $error("destination did not advance by one");
   chk_iip_on_intr: assert property ( // [RL4]
      intr_taken |-> old_psw_out[dsx_pkg::PSW_IIP_BIT] && !busy && s_reg.instruction_in_progress_flag)
      else $error("interrupt without in-progress flag");
   chk_store_sign: assert property ( // [RL20]
      s_reg.st == dsx_pkg::ST_ST_CONV && s_reg.dd == dsx_pkg::DD_LAST |=>
      s_reg.bcd[3:0] == ($past(s_reg.neg) ? dsx_pkg::SIGN_NEG : dsx_pkg::SIGN_POS))
      else $error("stored sign nibble not standard");
endmodule

// ===== dsx_pkg.sv
// Constants, state and context types of the decimal string execution unit.
// Assumes a 32-bit general register file and a byte-wide memory port.
package dsx_pkg;
   // ---------------------------------------------------------------
   // Opcodes
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_LOAD_PACKED = 8'h6f;
   localparam logic [7:0] OP_STORE_PACKED = 8'h6e;
   localparam logic [7:0] OP_MOVE_XLATE = 8'h8c;
   localparam logic [7:0] FN_MOVE_XLATE = 8'h00;
   // ---------------------------------------------------------------
   // Packed decimal layout
   // ---------------------------------------------------------------
   localparam logic [4:0] PACKED_LAST = 5'h0f;
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [3:0] SIGN_POS = 4'hc;
   localparam logic [3:0] SIGN_NEG = 4'hd;
   localparam logic [3:0] SIGN_NEG_ALT = 4'hb;
   localparam logic [3:0] SIGN_POS_3 = 4'h3;
   localparam logic [3:0] SIGN_POS_A = 4'ha;
   localparam logic [3:0] SIGN_POS_E = 4'he;
   localparam logic [3:0] SIGN_POS_F = 4'hf;
   localparam logic [67:0] DEC_BASE = 68'ha;
   localparam logic [63:0] MAG_MAX = 64'h7fff_ffff_ffff_ffff;
   localparam logic [6:0] DD_LAST = 7'h3f;
   localparam int BCD_DIGITS = 32;
   localparam logic [3:0] BCD_ADJ_MIN = 4'h5;
   localparam logic [3:0] BCD_ADJ = 4'h3;
   // ---------------------------------------------------------------
   // Condition code and status word
   // ---------------------------------------------------------------
   localparam int CC_C = 3;
   localparam int CC_V = 2;
   localparam int CC_G = 1;
   localparam int CC_L = 0;
   localparam logic [3:0] CC_NONE = 4'h0;
   localparam logic [3:0] CC_ESC = 4'h8;
   localparam logic [3:0] CC_OVF = 4'h4;
   localparam logic [3:0] CC_GT = 4'h2;
   localparam logic [3:0] CC_LT = 4'h1;
   localparam int PSW_IIP_BIT = 14;
   localparam int ESC_HI = 7;

   typedef enum logic [3:0] {
      ST_IDLE, ST_LD_RD, ST_LD_FIN, ST_ST_CONV, ST_ST_WR, ST_MV_SRC, ST_MV_TAB, ST_MV_WR
   } dsx_state_t;

   typedef struct packed {
      dsx_state_t st;
      dsx_state_t saved;
      logic busy;
      logic instruction_in_progress_flag;
      logic [4:0] cnt;
      logic [63:0] acc;
      logic ovf;
      logic neg;
      logic zero;
      logic [127:0] bcd;
      logic [6:0] dd;
      logic [31:0] src;
      logic [31:0] dst;
      logic [31:0] rem1;
      logic [31:0] rem2;
      logic [31:0] tab;
      logic [7:0] esc;
      logic mem_req;
      logic mem_we;
      logic [31:0] mem_addr;
      logic [7:0] mem_wdata;
      logic pair_we;
      logic [63:0] pair;
      logic gpr1_we;
      logic [31:0] gpr1;
      logic cc_we;
      logic [3:0] cc;
      logic fault;
      logic done;
      logic intr_taken;
      logic [31:0] old_psw;
   } dsx_ctx_t;

   localparam dsx_ctx_t CTX_RESET = '0;
endpackage

// ===== dsx_mem_model.sv
// Byte memory on the far side of the execution unit.
// Assumes each request is held until mem_ack; latency is set by the bench.
`timescale 1ns/1ps
module dsx_mem_model (
   input wire logic ref_clk,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic [2:0] delay,
   output logic [7:0] mem_rdata,
   output logic mem_ack
);
   logic [7:0] mem [0:511];
   logic [2:0] cnt_reg;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 8'h5a;
      cnt_reg = 3'h0;
   end
   // Read data valid only in the ack cycle; toggles otherwise so stale use shows
   always @(posedge ref_clk) begin
      mem_rdata <= ~mem_rdata;
      if (mem_ack) begin
         mem_ack <= 1'b0;
         cnt_reg <= 3'h0;
         if (mem_we) mem[mem_addr[8:0]] <= mem_wdata;
      end else if (mem_req && cnt_reg >= delay) begin
         mem_ack <= 1'b1;
         if (!mem_we) mem_rdata <= mem[mem_addr[8:0]];
      end else if (mem_req) begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end
endmodule

// ===== test_decimal_string_exec_unit.sv
// Self-checking bench for the decimal string execution unit.
// Assumes the memory model answers every request; one clock, sync reset.
`timescale 1ns/1ps
module test_decimal_string_exec_unit;
   logic ref_clk, rst_n, start, resume, len1_from_reg, len2_from_reg, intr_req, mem_ack;
   logic [7:0] opcode, func_code, mem_rdata, mem_wdata;
   logic [31:0] pair_even_in, pair_odd_in, gpr0_in, gpr2_in, len1_reg, len2_reg, addr1, addr2;
   logic [3:0] len1_imm, len2_imm, cc_out;
   logic [0:31] psw_in, old_psw_out, ps;
   logic [2:0] delay;
   logic busy, done, mem_req, mem_we, pair_we, gpr1_we, cc_we, fmt_fault, intr_taken;
   logic [31:0] mem_addr, pair_even_out, pair_odd_out, gpr1_out;
   logic [136:0] exp_q [$];
   logic [127:0] r, e;
   logic [63:0] m, v;
   logic [31:0] seed = 32'h0001_8262;
   logic [7:0] a;
   logic [3:0] cc;
   logic n;
   int bad_count = 0, check_count = 0, k;
   int sl [6] = '{6, 6, 4, 8, 0, 15};
   int dl [6] = '{10, 2, 8, 8, 3, 15};
   logic [7:0] eb [6] = '{8'h44, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [3:0] sg [8] = '{4'hc, 4'hc, 4'h3, 4'ha, 4'he, 4'hf, 4'hd, 4'hb};

   dsx_exec_unit dsx_exec_unit_inst (.*);
   dsx_mem_model dsx_mem_model_inst (.*);

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [63:0] rnd();
      logic [63:0] x;
      for (int i = 0; i < 64; i++) begin
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
         x = {x[62:0], seed[0]};
      end
      return x;
   endfunction
   function automatic logic [127:0] pk(input logic [63:0] mg, input logic [3:0] s);
      logic [127:0] p;
      p = {124'h0, s};
      for (int i = 1; i < 32; i++) begin
         p[i*4 +: 4] = 4'(mg % 64'ha);
         mg = mg / 64'ha;
      end
      return p;
   endfunction
   function automatic logic [127:0] get(input int ad);
      logic [127:0] p;
      for (int i = 0; i < 16; i++) p[127-8*i -: 8] = dsx_mem_model_inst.mem[ad+i];
      return p;
   endfunction
   function automatic logic [136:0] ex(input logic i, f, p, c, g, input logic [3:0] cv,
      input logic [63:0] pv, input logic [31:0] g1, input logic [0:31] os);
      return {i, f, p, c, g, cv, pv, g1, os};
   endfunction
   // Cc is masked on a fault: its value there is left open
   function automatic logic [136:0] snap();
      logic c;
      c = cc_we && !fmt_fault;
      return {intr_taken, fmt_fault, pair_we, c, gpr1_we, c ? cc_out : 4'h0,
         pair_we ? {pair_even_out, pair_odd_out} : 64'h0, gpr1_we ? gpr1_out : 32'h0,
         intr_taken ? old_psw_out : 32'h0};
   endfunction
   task automatic chk(input string nm, input logic [136:0] ev, gv);
      check_count++;
      if (ev !== gv) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, ev, gv);
      end
   endtask
   task automatic end_sim();
      if (bad_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic run(input logic [7:0] op);
      opcode <= op;
      delay <= 3'(rnd());
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      resume <= 1'b0;
      for (int i = 0; i < 3000; i++) begin
         @(posedge ref_clk);
         if (done === 1'b1 || intr_taken === 1'b1) return;
      end
      bad_count++;
      end_sim();
   endtask

   // ---------------------------------------------------------------
   // Result monitor
   // ---------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (rst_n === 1'b1 && (done === 1'b1 || intr_taken === 1'b1)) begin
         chk("result", exp_q.size() > 0 ? exp_q.pop_front() : '1, snap());
      end
   end

   // ---------------------------------------------------------------
   // Stimulus
   // ---------------------------------------------------------------
   initial begin
      {rst_n, start, resume, len1_from_reg, len2_from_reg, intr_req, opcode, func_code} = '0;
      {pair_even_in, pair_odd_in, gpr0_in, gpr2_in, len1_reg, len2_reg, addr1, addr2} = '0;
      {len1_imm, len2_imm, psw_in, delay} = '0;
      for (k = 0; k < 256; k++) dsx_mem_model_inst.mem[256+k] = ~8'(k);
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         m = i == 0 ? 64'h0 : i == 1 ? dsx_pkg::MAG_MAX : rnd() >> 2;
         n = sg[i] inside {dsx_pkg::SIGN_NEG, dsx_pkg::SIGN_NEG_ALT};
         v = n ? -m : m;
         r = pk(m, sg[i]);
         for (k = 0; k < 16; k++) dsx_mem_model_inst.mem[k] = r[127-8*k -: 8];
         cc = m == 0 ? dsx_pkg::CC_NONE : n ? dsx_pkg::CC_LT : dsx_pkg::CC_GT;
         exp_q.push_back(ex(0, 0, 1, 1, 0, cc, v, 0, 0));
         run(dsx_pkg::OP_LOAD_PACKED);
      end
      for (int j = 0; j < 3; j++) begin
         r = pk(dsx_pkg::MAG_MAX + 64'h1, j == 1 ? 4'h5 : dsx_pkg::SIGN_POS);
         if (j == 2) r[60 +: 4] = 4'ha;
         for (k = 0; k < 16; k++) dsx_mem_model_inst.mem[k] = r[127-8*k -: 8];
         exp_q.push_back(j == 0 ? ex(0, 0, 0, 1, 0, dsx_pkg::CC_OVF, 0, 0, 0) :
            ex(0, 1, 0, 0, 0, 0, 0, 0, 0));
         run(dsx_pkg::OP_LOAD_PACKED);
      end
      // store to 0x10; even register pair by construction
      addr2 <= 32'h10;
      for (int j = 0; j < 3; j++) begin
         v = j == 0 ? 64'h0 : j == 1 ? rnd() >> 1 : -(rnd() >> 1);
         n = v[63];
         pair_even_in <= v[63:32];
         pair_odd_in <= v[31:0];
         cc = v == 0 ? dsx_pkg::CC_NONE : n ? dsx_pkg::CC_LT : dsx_pkg::CC_GT;
         exp_q.push_back(ex(0, 0, 0, 1, 0, cc, 0, 0, 0));
         run(dsx_pkg::OP_STORE_PACKED);
         r = pk(n ? -v : v, n ? dsx_pkg::SIGN_NEG : dsx_pkg::SIGN_POS);
         chk("packed", r, get(16));
      end
      addr1 <= 32'h40;
      addr2 <= 32'h20;
      func_code <= dsx_pkg::FN_MOVE_XLATE;
      for (int c = 0; c < 6; c++) begin
         e = {16{8'hee}};
         for (k = 0; k < 16; k++) dsx_mem_model_inst.mem[32+k] = 8'h41 + 8'(k);
         for (k = 0; k < 16; k++) dsx_mem_model_inst.mem[64+k] = 8'hee;
         gpr2_in <= (c == 1 || c == 2 || c == 5) ? 32'h100 : 32'h0;
         gpr0_in <= {24'(rnd()), eb[c]};
         {len1_from_reg, len2_from_reg} <= {c[0], !c[0]};
         {len1_imm, len2_imm} <= {4'(dl[c]), 4'(sl[c])};
         {len1_reg, len2_reg} <= {32'(dl[c]), 32'(sl[c])};
         cc = dsx_pkg::CC_NONE;
         for (k = 0; k < sl[c]; k++) begin
            a = (c == 1 || c == 2 || c == 5) ? ~(8'h41 + 8'(k)) : 8'h41 + 8'(k);
            if (k == dl[c]) cc = dsx_pkg::CC_OVF;
            if (k < dl[c] && a == eb[c]) cc = dsx_pkg::CC_ESC;
            if (cc != dsx_pkg::CC_NONE) break;
            e[127-8*k -: 8] = a;
         end
         if (c == 3) begin
            ps = 32'(rnd());
            ps[dsx_pkg::PSW_IIP_BIT] = 1'b0;
            psw_in <= ps;
            ps[dsx_pkg::PSW_IIP_BIT] = 1'b1;
            intr_req <= 1'b1;
            exp_q.push_back(ex(1, 0, 0, 0, 0, 0, 0, 0, ps));
            run(dsx_pkg::OP_MOVE_XLATE);
            intr_req <= 1'b0;
            resume <= 1'b1;
         end
         exp_q.push_back(ex(0, 0, 0, 1, 1, cc, 0, 32'h20 + 32'(k), 0));
         run(dsx_pkg::OP_MOVE_XLATE);
         chk("dest", e, get(64));
      end
      // unknown opcode and function give a bare done
      for (int j = 0; j < 2; j++) begin
         func_code <= 8'h01;
         exp_q.push_back(ex(0, 0, 0, 0, 0, 0, 0, 0, 0));
         run(j == 0 ? 8'h00 : dsx_pkg::OP_MOVE_XLATE);
      end
      repeat (2) @(posedge ref_clk);
      chk("pending", 0, exp_q.size());
      end_sim();
   end
endmodule
